// >>> rtl/ioh_cfg.svh
// Constants of the isolated output host port
`ifndef IOH_CFG_SVH
`define IOH_CFG_SVH
`define IOH_ADDR_RESET 8'h80
`define IOH_ADDR_WR_BIT 7
`define IOH_REG_DRIVE 7'h00
`define IOH_REG_OT 7'h01
`define IOH_REG_OLA 7'h02
`define IOH_REG_OCL 7'h03
`define IOH_REG_OLI 7'h04
`define IOH_REG_SCV 7'h05
`define IOH_REG_GLB 7'h06
`define IOH_GLB_UV 0
`define IOH_GLB_MV 1
`define IOH_GLB_COT 2
`define IOH_GLB_ALL_OUTPUTS_OFF_FLAG 3
`define IOH_GLB_CHKERR 4
`define IOH_GLB_TFAIL 5
`define IOH_FRAME_W 24
`define IOH_CNT_W 5
`define IOH_LEN_DRIVE 5'h08
`define IOH_LEN_DRIVE_CHK 5'h10
`define IOH_LEN_REG 5'h10
`define IOH_LEN_REG_CHK 5'h18
`define IOH_CHK_SEED 8'ha5
`define IOH_BOOT_CYC 2'h3
`define IOH_MCLK_NS 8
`define IOH_OUTPUT_DISABLE_N_MIN_NS 5000
`define IOH_OUTPUT_DISABLE_N_MIN_CYC ((`IOH_OUTPUT_DISABLE_N_MIN_NS + `IOH_MCLK_NS - 1) / `IOH_MCLK_NS)
`endif

// >>> rtl/ioh_pkg.sv
// Types of the isolated output host port
package ioh_pkg;
  typedef enum logic [1:0] {
    IOH_SM_DRIVE = 2'h0,
    IOH_SM_DRIVE_CHK = 2'h1,
    IOH_SM_REG = 2'h2,
    IOH_SM_REG_CHK = 2'h3
  } ioh_smode_t;
  typedef enum logic [1:0] {
    IOH_ST_BOOT = 2'h0,
    IOH_ST_CFG = 2'h1,
    IOH_ST_PAR = 2'h3,
    IOH_ST_SER = 2'h2
  } ioh_state_t;
endpackage : ioh_pkg

// >>> rtl/ioh_sync.sv
// Two-flop synchroniser for a bundle of pin levels
module ioh_sync #(
  parameter int W = 1
) (
  input logic mclk,
  input logic reset_n,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  if (W < 1) begin : g_chk
    $error("ioh_sync width must be positive");
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : ioh_sync

// >>> rtl/ioh_shift.sv
// Serial input shift buffer with bit counter
`include "ioh_cfg.svh"
module ioh_shift #(
  parameter int W = `IOH_FRAME_W
) (
  input logic mclk,
  input logic reset_n,
  input logic clear,
  input logic sample,
  input logic bit_in,
  output logic [W-1:0] frame_q,
  output logic [`IOH_CNT_W-1:0] count_q
);
  if (W < 2 || W >= (1 << `IOH_CNT_W)) begin : g_chk
    $error("ioh_shift width out of range");
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      frame_q <= '0;
      count_q <= '0;
    end else if (clear) begin
      frame_q <= '0;
      count_q <= '0;
    end else if (sample) begin
      frame_q <= {frame_q[W-2:0], bit_in};
      if (count_q != '1) begin
        count_q <= count_q + 1'b1;
      end
    end
  end
endmodule : ioh_shift

// >>> rtl/ioh_port.sv
// Host port of the isolated eight-channel output driver
//
// Summary of operation
// - Output disable low switches outputs off instantly
// - Output disable also clears the drive register
// - Fault output ORs supply, link, switch faults
// - Write captured on strobe rise, address top one
// - Read drives data from strobe fall, top zero
// - Latch enable high latches bus as address
// - Accesses reuse latched address, no increment
// - Bus released while select and strobes high
// - Write strobe held low with read high gives direct mode, outputs follow
// - Direct mode faults track power wait, overtemperature
// - Address presets to write drive after reset
// - Serial output released while select is high
// - Serial input shifts on clock rise, 8/16/24
// - Serial output advances on each clock fall
// - Four framing modes from two mode bits
// - Five diagnostics, gated by channel on or off state
// - All-off flag when every driver disabled
// - Undervoltage and missing supply flags reported
// - Global overtemperature flag never shuts outputs
// - Transfers accepted only with select low
// - Modes: drive, drive checked, register, register checked
// - Mode select low means parallel, sampled once
`include "ioh_cfg.svh"
module ioh_port
  import ioh_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input logic mclk,
  input logic reset_n,
  input logic output_disable_n,
  input logic chip_select_n,
  input logic write_n,
  input logic read_n,
  input logic addr_latch_en,
  input logic serial_select,
  input logic serial_mode_bit0,
  input logic serial_mode_bit1,
  input logic serial_clk,
  input logic serial_data_in,
  input logic [CHANNELS-1:0] addr_data_bus_in,
  output logic [CHANNELS-1:0] addr_data_bus_out,
  output logic addr_data_bus_oe,
  output logic serial_data_out,
  output logic serial_data_oe,
  output logic fault_n_out,
  output logic fault_n_oe,
  output logic [CHANNELS-1:0] channel_outputs,
  input logic [CHANNELS-1:0] channel_overtemp_in,
  input logic [CHANNELS-1:0] open_load_on_in,
  input logic [CHANNELS-1:0] overload_in,
  input logic [CHANNELS-1:0] open_load_off_in,
  input logic [CHANNELS-1:0] short_to_supply_in,
  input logic [CHANNELS-1:0] channel_overtemp_fault,
  input logic undervoltage_in,
  input logic missing_supply_in,
  input logic chip_overtemp_in,
  input logic wait_for_power_fault,
  input logic transmission_fail_in,
  output logic undervoltage_flag,
  output logic missing_supply_flag,
  output logic chip_overtemp_flag,
  output logic all_outputs_off_flag,
  output logic check_error_flag
);
  localparam int PW = 10 + CHANNELS;
  localparam int DW = 6 * CHANNELS + 5;

  if (CHANNELS != 8) begin : g_chk
    $error("ioh_port serves exactly eight channels");
  end

  logic [PW-1:0] pin_s;
  logic [DW-1:0] dia_s;
  logic output_disable_n_s, cs_s, wr_s, rd_s, ale_s, sel_s, ms1_s, ms0_s, sclk_s, sdi_s;
  logic [CHANNELS-1:0] din_s, ot_s, ola_s, ocl_s, oli_s, scv_s, shut_s;
  logic uv_s, mv_s, cot_s, w4p_s, tf_s;

  ioh_sync #(.W(PW)) u_pin_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({output_disable_n, chip_select_n, write_n, read_n, addr_latch_en, serial_select,
        serial_mode_bit1, serial_mode_bit0, serial_clk, serial_data_in, addr_data_bus_in}),
    .q(pin_s)
  );
  ioh_sync #(.W(DW)) u_diag_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d({channel_overtemp_in, open_load_on_in, overload_in, open_load_off_in,
        short_to_supply_in, channel_overtemp_fault, undervoltage_in, missing_supply_in,
        chip_overtemp_in, wait_for_power_fault, transmission_fail_in}),
    .q(dia_s)
  );
  assign {output_disable_n_s, cs_s, wr_s, rd_s, ale_s, sel_s, ms1_s, ms0_s, sclk_s, sdi_s, din_s} = pin_s;
  assign {ot_s, ola_s, ocl_s, oli_s, scv_s, shut_s, uv_s, mv_s, cot_s, w4p_s, tf_s} = dia_s;

  // Edge detectors look only at synchronised levels
  logic wr_prev_q, rd_prev_q, sclk_prev_q, cs_prev_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_prev_q <= 1'b1;
      rd_prev_q <= 1'b1;
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end else begin
      wr_prev_q <= wr_s;
      rd_prev_q <= rd_s;
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_s;
    end
  end

  // Start-up: interface mode is caught once after the pipeline fills
  ioh_state_t st_q;
  logic [1:0] boot_cnt_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= IOH_ST_BOOT;
      boot_cnt_q <= 2'h0;
    end else begin
      case (st_q)
        IOH_ST_BOOT: begin
          boot_cnt_q <= boot_cnt_q + 2'h1;
          if (boot_cnt_q == `IOH_BOOT_CYC) begin
            st_q <= IOH_ST_CFG;
          end
        end
        IOH_ST_CFG: st_q <= sel_s ? IOH_ST_SER : IOH_ST_PAR;
        IOH_ST_PAR: st_q <= IOH_ST_PAR;
        IOH_ST_SER: st_q <= IOH_ST_SER;
        default: st_q <= IOH_ST_BOOT;
      endcase
    end
  end

  logic par, ser;
  assign par = (st_q == IOH_ST_PAR);
  assign ser = (st_q == IOH_ST_SER);

  logic [7:0] addr_q, drive_q;
  logic [CHANNELS-1:0] ot_q, ola_q, ocl_q, oli_q, scv_q;
  logic uv_q, mv_q, cot_q, all_outputs_off_flag_q, chk_err_q;
  logic [7:0] glb;
  assign glb = {2'h0, tf_s, chk_err_q, all_outputs_off_flag_q, cot_q, mv_q, uv_q};

  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a[6:0])
      `IOH_REG_DRIVE: rd_mux = drive_q;
      `IOH_REG_OT: rd_mux = ot_q;
      `IOH_REG_OLA: rd_mux = ola_q;
      `IOH_REG_OCL: rd_mux = ocl_q;
      `IOH_REG_OLI: rd_mux = oli_q;
      `IOH_REG_SCV: rd_mux = scv_q;
      `IOH_REG_GLB: rd_mux = glb;
      default: rd_mux = 8'h00;
    endcase
  endfunction : rd_mux

  function automatic logic chk_ok(input logic [7:0] d, input logic [7:0] c);
    chk_ok = ((d ^ `IOH_CHK_SEED) == c);
  endfunction : chk_ok

  // Parallel strobes
  logic par_sel, ale_take, wr_rise, rd_fall, wr_drive, direct;
  assign par_sel = par && !cs_s;
  assign ale_take = par_sel && ale_s;
  assign wr_rise = par_sel && !ale_s && !wr_prev_q && wr_s;
  assign rd_fall = par_sel && !ale_s && rd_prev_q && !rd_s && !addr_q[`IOH_ADDR_WR_BIT];
  assign wr_drive = addr_q[`IOH_ADDR_WR_BIT] && (addr_q[6:0] == `IOH_REG_DRIVE);
  assign direct = par_sel && !wr_s && rd_s && !ale_s;

  // Serial framing
  logic [`IOH_FRAME_W-1:0] frame;
  logic [`IOH_CNT_W-1:0] bit_cnt;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  assign sclk_rise = ser && !cs_s && !sclk_prev_q && sclk_s;
  assign sclk_fall = ser && !cs_s && sclk_prev_q && !sclk_s;
  assign cs_rise = ser && !cs_prev_q && cs_s;
  assign cs_fall = ser && cs_prev_q && !cs_s;

  ioh_shift #(.W(`IOH_FRAME_W)) u_shift (
    .mclk(mclk),
    .reset_n(reset_n),
    .clear(cs_fall),
    .sample(sclk_rise),
    .bit_in(sdi_s),
    .frame_q(frame),
    .count_q(bit_cnt)
  );

  logic ser_drv_ld, ser_addr_ld, ser_bad;
  logic [7:0] ser_drv, ser_a, ser_d;
  logic [`IOH_CNT_W-1:0] ser_len;
  always_comb begin
    ser_a = 8'h00;
    ser_d = frame[7:0];
    ser_bad = 1'b0;
    ser_len = `IOH_LEN_DRIVE;
    case (ioh_smode_t'({ms1_s, ms0_s}))
      IOH_SM_DRIVE: begin
        ser_a = `IOH_ADDR_RESET;
      end
      IOH_SM_DRIVE_CHK: begin
        ser_len = `IOH_LEN_DRIVE_CHK;
        ser_a = `IOH_ADDR_RESET;
        ser_d = frame[15:8];
        ser_bad = !chk_ok(frame[15:8], frame[7:0]);
      end
      IOH_SM_REG: begin
        ser_len = `IOH_LEN_REG;
        ser_a = frame[15:8];
      end
      IOH_SM_REG_CHK: begin
        ser_len = `IOH_LEN_REG_CHK;
        ser_a = frame[23:16];
        ser_d = frame[15:8];
        ser_bad = !chk_ok(frame[15:8], frame[7:0]);
      end
      default: ser_len = `IOH_LEN_DRIVE;
    endcase
    ser_drv = ser_d;
    ser_drv_ld = cs_rise && (bit_cnt == ser_len) && !ser_bad &&
                 ser_a[`IOH_ADDR_WR_BIT] && (ser_a[6:0] == `IOH_REG_DRIVE);
    ser_addr_ld = cs_rise && (bit_cnt == ser_len) && !ser_bad && !ser_a[`IOH_ADDR_WR_BIT];
  end

  // Address register; no increment between accesses
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= `IOH_ADDR_RESET;
    end else if (ale_take) begin
      addr_q <= din_s;
    end else if (ser_addr_ld) begin
      addr_q <= ser_a;
    end
  end

  // Drive register, cleared asynchronously by output disable
  logic clr_n;
  assign clr_n = reset_n & output_disable_n;
  always_ff @(posedge mclk or negedge clr_n) begin
    if (!clr_n) begin
      drive_q <= 8'h00;
    end else if (wr_rise && wr_drive) begin
      drive_q <= din_s;
    end else if (direct && wr_drive) begin
      drive_q <= din_s;
    end else if (ser_drv_ld) begin
      drive_q <= ser_drv;
    end
  end

  always_ff @(posedge mclk or negedge clr_n) begin
    if (!clr_n) begin
      channel_outputs <= '0;
    end else begin
      channel_outputs <= drive_q;
    end
  end

  // Diagnostics follow the on or off state of each channel
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ot_q <= '0;
      ola_q <= '0;
      ocl_q <= '0;
      oli_q <= '0;
      scv_q <= '0;
    end else begin
      ot_q <= ot_s & drive_q;
      ola_q <= ola_s & drive_q;
      ocl_q <= ocl_s & drive_q;
      oli_q <= oli_s & ~drive_q;
      scv_q <= scv_s & ~drive_q;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      uv_q <= 1'b1;
      mv_q <= 1'b1;
      cot_q <= 1'b0;
      all_outputs_off_flag_q <= 1'b1;
    end else begin
      uv_q <= uv_s;
      mv_q <= mv_s;
      cot_q <= cot_s;
      all_outputs_off_flag_q <= (drive_q == 8'h00) || !output_disable_n_s || (&shut_s);
    end
  end

  // Check error: a new failure wins over a clearing read
  logic glb_read;
  assign glb_read = (rd_fall && (addr_q[6:0] == `IOH_REG_GLB)) || cs_fall;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      chk_err_q <= 1'b0;
    end else if (cs_rise && ser_bad && (bit_cnt == ser_len)) begin
      chk_err_q <= 1'b1;
    end else if (glb_read) begin
      chk_err_q <= 1'b0;
    end
  end

  // Parallel read data and bus drive
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_data_bus_out <= '0;
      addr_data_bus_oe <= 1'b0;
    end else begin
      if (rd_fall) begin
        addr_data_bus_out <= rd_mux(addr_q);
      end
      addr_data_bus_oe <= par_sel && !rd_s && !ale_s && !addr_q[`IOH_ADDR_WR_BIT];
    end
  end

  // Serial read data shifts out on falling clock edges
  logic [`IOH_FRAME_W-1:0] tx_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_q <= '0;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else begin
      serial_data_oe <= ser && !cs_s;
      if (cs_fall) begin
        tx_q <= {glb, rd_mux(addr_q), 8'h00};
        serial_data_out <= glb[7];
      end else if (sclk_fall) begin
        tx_q <= {tx_q[`IOH_FRAME_W-2:0], 1'b0};
        serial_data_out <= tx_q[`IOH_FRAME_W-2];
      end
    end
  end

  // Fault pin pulls low while any selected fault is present
  logic fault_d;
  always_comb begin
    if (direct) begin
      fault_d = w4p_s || (|shut_s);
    end else if (par || ser) begin
      fault_d = uv_q || mv_q || tf_s || chk_err_q ||
                (|(ot_q | ola_q | ocl_q | oli_q | scv_q));
    end else begin
      fault_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fault_n_out <= 1'b0;
      fault_n_oe <= 1'b1;
    end else begin
      fault_n_out <= 1'b0;
      fault_n_oe <= fault_d;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      undervoltage_flag <= 1'b1;
      missing_supply_flag <= 1'b1;
      chip_overtemp_flag <= 1'b0;
      all_outputs_off_flag <= 1'b1;
      check_error_flag <= 1'b0;
    end else begin
      undervoltage_flag <= uv_q;
      missing_supply_flag <= mv_q;
      chip_overtemp_flag <= cot_q;
      all_outputs_off_flag <= all_outputs_off_flag_q;
      check_error_flag <= chk_err_q;
    end
  end

  AST_OUTPUT_DISABLE_N_OFF: assert property (@(posedge mclk) disable iff (!reset_n)
    !output_disable_n |-> channel_outputs == '0) else $error("outputs on under disable");
  AST_OUTPUT_DISABLE_N_CLR: assert property (@(posedge mclk) disable iff (!reset_n)
    !output_disable_n |-> drive_q == 8'h00) else $error("drive kept under disable");
  AST_WR_CAP: assert property (@(posedge mclk) disable iff (!reset_n)
    (wr_rise && wr_drive && output_disable_n) ##1 output_disable_n |->
    drive_q == $past(din_s)) else $error("write not captured");
  AST_RD_DRV: assert property (@(posedge mclk) disable iff (!reset_n)
    rd_fall |=> addr_data_bus_oe && addr_data_bus_out == $past(rd_mux(addr_q)))
    else $error("read data not driven");
  AST_ALE_LAT: assert property (@(posedge mclk) disable iff (!reset_n)
    ale_take |=> addr_q == $past(din_s)) else $error("address not latched");
  AST_ADDR_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
    (par && !ale_s) |=> $stable(addr_q)) else $error("address moved without latch");
  AST_BUS_Z: assert property (@(posedge mclk) disable iff (!reset_n)
    (cs_s && rd_s && wr_s) |=> !addr_data_bus_oe) else $error("bus driven while idle");
  AST_DIRECT_ERR: assert property (@(posedge mclk) disable iff (!reset_n)
    (direct && w4p_s) |=> fault_n_oe) else $error("direct fault not shown");
  AST_SDO_Z: assert property (@(posedge mclk) disable iff (!reset_n)
    cs_s |=> !serial_data_oe) else $error("serial out driven while deselected");
  AST_DIAG_GATE: assert property (@(posedge mclk) disable iff (!reset_n)
    ##1 ((ot_q | ocl_q) & ~$past(drive_q)) == '0) else $error("on diag while off");
  AST_ALL_OUTPUTS_OFF_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
    (drive_q == 8'h00) |=> all_outputs_off_flag_q ##1 all_outputs_off_flag) else $error("all-off missing");
endmodule : ioh_port

// >>> tb/ioh_host.sv
// Host controller model for the parallel and serial pins
module ioh_host (
  input wire logic mclk,
  input wire logic [7:0] dut_bus,
  input wire logic dut_bus_oe,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic ale,
  output logic sclk,
  output wire logic sdi,
  output wire logic [7:0] bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] val = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic drv_on = 1'b0;
  logic sdi_q = 1'b0;
  logic tog_q = 1'b0;
  initial begin
    {cs_n, wr_n, rd_n, ale, sclk} = 5'h1c;
  end
  // Released lines toggle so a stale value never passes for data
  always @(posedge mclk) begin
    last_q <= bus;
    tog_q <= ~tog_q;
  end
  assign bus = dut_bus_oe ? dut_bus : (drv_on ? val : ~last_q);
  assign sdi = cs_n ? tog_q : sdi_q;
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  task automatic latch(input logic [7:0] a);
    @(posedge mclk);
    cs_n <= 1'b0;
    ale <= 1'b1;
    drv_on <= 1'b1;
    val <= a;
    cyc(4);
    ale <= 1'b0;
  endtask : latch
  task automatic write(input logic [7:0] a, input logic [7:0] d, input logic new_addr);
    if (new_addr) latch(a | 8'h80);
    @(posedge mclk);
    cs_n <= 1'b0;
    drv_on <= 1'b1;
    val <= d;
    wr_n <= 1'b0;
    cyc(4);
    wr_n <= 1'b1;
    cyc(4);
    cs_n <= 1'b1;
    drv_on <= 1'b0;
    cyc(4);
  endtask : write
  task automatic read(input logic [7:0] a, output logic [7:0] d, output logic on,
                      output logic off);
    latch(a & 8'h7f);
    drv_on <= 1'b0;
    @(posedge mclk);
    rd_n <= 1'b0;
    cyc(5);
    #1;
    d = bus;
    on = dut_bus_oe;
    @(posedge mclk);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    cyc(5);
    #1;
    off = dut_bus_oe;
  endtask : read
  task automatic direct(input logic on, input logic [7:0] d);
    @(posedge mclk);
    cs_n <= ~on;
    wr_n <= ~on;
    drv_on <= on;
    val <= d;
  endtask : direct
  task automatic frame(input logic [23:0] b, input int n, output logic [23:0] got,
                       output logic oe);
    got = 24'h0;
    oe = 1'b1;
    @(posedge mclk);
    cs_n <= 1'b0;
    sdi_q <= b[n-1];
    cyc(4);
    for (int i = n - 1; i >= 0; i--) begin
      got[i] = sdo;
      oe &= sdo_oe;
      sclk <= 1'b1;
      cyc(4);
      sclk <= 1'b0;
      if (i > 0) sdi_q <= b[i-1];
      cyc(4);
    end
    cs_n <= 1'b1;
    cyc(6);
  endtask : frame
endmodule : ioh_host

// >>> tb/ioh_port_test.sv
// Self-checking bench for the isolated output host port
`include "ioh_cfg.svh"
module ioh_port_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic output_disable_n = 1'b1;
  logic serial_select = 1'b0;
  logic serial_mode_bit0 = 1'b0;
  logic serial_mode_bit1 = 1'b0;
  logic [7:0] channel_overtemp_in = 8'h00;
  logic [7:0] open_load_on_in = 8'h00;
  logic [7:0] overload_in = 8'h00;
  logic [7:0] open_load_off_in = 8'h00;
  logic [7:0] short_to_supply_in = 8'h00;
  logic [7:0] channel_overtemp_fault = 8'h00;
  logic undervoltage_in = 1'b0;
  logic missing_supply_in = 1'b0;
  logic chip_overtemp_in = 1'b0;
  logic wait_for_power_fault = 1'b0;
  logic transmission_fail_in = 1'b0;
  wire logic chip_select_n, write_n, read_n, addr_latch_en, serial_clk, serial_data_in;
  wire logic [7:0] addr_data_bus_in;
  logic [7:0] addr_data_bus_out, channel_outputs;
  logic addr_data_bus_oe, serial_data_out, serial_data_oe, fault_n_out, fault_n_oe;
  logic undervoltage_flag, missing_supply_flag, chip_overtemp_flag, all_outputs_off_flag;
  logic check_error_flag;
  wire logic fault_pin;
  int fails = 0;
  int n_compared = 0;
  int seed = 38;
  // Open-drain fault line with its pull-up
  assign fault_pin = fault_n_oe ? fault_n_out : 1'b1;
  ioh_port #(.CHANNELS(8)) DUT (.mclk, .reset_n, .output_disable_n, .chip_select_n, .write_n,
    .read_n, .addr_latch_en, .serial_select, .serial_mode_bit0, .serial_mode_bit1, .serial_clk,
    .serial_data_in, .addr_data_bus_in, .addr_data_bus_out, .addr_data_bus_oe, .serial_data_out,
    .serial_data_oe, .fault_n_out, .fault_n_oe, .channel_outputs, .channel_overtemp_in,
    .open_load_on_in, .overload_in, .open_load_off_in, .short_to_supply_in,
    .channel_overtemp_fault, .undervoltage_in, .missing_supply_in, .chip_overtemp_in,
    .wait_for_power_fault, .transmission_fail_in, .undervoltage_flag, .missing_supply_flag,
    .chip_overtemp_flag, .all_outputs_off_flag, .check_error_flag);
  ioh_host host (.mclk, .dut_bus(addr_data_bus_out), .dut_bus_oe(addr_data_bus_oe),
    .sdo(serial_data_out), .sdo_oe(serial_data_oe), .cs_n(chip_select_n), .wr_n(write_n),
    .rd_n(read_n), .ale(addr_latch_en), .sclk(serial_clk), .sdi(serial_data_in),
    .bus(addr_data_bus_in));
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : settle
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  function automatic logic [7:0] diag_exp(input int r, input logic [7:0] drv);
    case (r)
      0: diag_exp = drv;
      1: diag_exp = channel_overtemp_in & drv;
      2: diag_exp = open_load_on_in & drv;
      3: diag_exp = overload_in & drv;
      4: diag_exp = open_load_off_in & ~drv;
      5: diag_exp = short_to_supply_in & ~drv;
      default: diag_exp = 8'h00;
    endcase
  endfunction : diag_exp
  function automatic logic [23:0] ser_bits(input int m, input logic [7:0] d);
    case (m)
      0: ser_bits = {16'h0000, d};
      1: ser_bits = {8'h00, d, d ^ `IOH_CHK_SEED};
      2: ser_bits = {8'h00, 8'h80, d};
      default: ser_bits = {8'h80, d, d ^ `IOH_CHK_SEED};
    endcase
  endfunction : ser_bits
  task automatic do_reset(input logic sel);
    @(posedge mclk);
    reset_n <= 1'b0;
    serial_select <= sel;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    settle(10);
  endtask : do_reset
  initial begin
    logic [7:0] d, drv;
    logic on, off;
    logic [23:0] got;
    int len;
    do_reset(1'b0);
    check(fault_pin, 1'b1);
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      host.direct(1'b1, d);
      settle(6);
      check(channel_outputs, d);
    end
    wait_for_power_fault <= 1'b1;
    settle(5);
    check(fault_pin, 1'b0);
    wait_for_power_fault <= 1'b0;
    channel_overtemp_fault <= 8'h04;
    settle(5);
    check(fault_pin, 1'b0);
    channel_overtemp_fault <= 8'h00;
    settle(5);
    check(fault_pin, 1'b1);
    host.direct(1'b0, 8'h00);
    settle(6);
    for (int i = 0; i < 4; i++) begin
      drv = (i == 0) ? 8'h00 : ((i == 3) ? 8'hff : 8'($random(seed)));
      channel_overtemp_in <= 8'($random(seed));
      open_load_on_in <= 8'($random(seed));
      overload_in <= 8'($random(seed));
      open_load_off_in <= 8'($random(seed));
      short_to_supply_in <= 8'($random(seed));
      host.write(8'h00, ~drv, 1'b1);
      host.write(8'h00, drv, 1'b0);
      settle(2);
      check(channel_outputs, drv);
      check(all_outputs_off_flag, drv == 8'h00);
      host.write(8'h01, ~drv, 1'b1);
      check(channel_outputs, drv);
      for (int r = 0; r < 8; r++) begin
        if (r == 6) continue;
        host.read(8'(r), d, on, off);
        check(d, diag_exp(r, drv));
        check({on, off}, 2'h2);
      end
    end
    channel_overtemp_fault <= 8'hff;
    settle(6);
    check(all_outputs_off_flag, 1'b1);
    {channel_overtemp_fault, channel_overtemp_in, open_load_on_in, overload_in} <= 32'h0;
    {open_load_off_in, short_to_supply_in} <= 16'h0;
    {undervoltage_in, missing_supply_in, chip_overtemp_in} <= 3'h7;
    settle(6);
    check({undervoltage_flag, missing_supply_flag}, 2'h3);
    check(chip_overtemp_flag, 1'b1);
    check(channel_outputs, 8'hff);
    check(fault_pin, 1'b0);
    {undervoltage_in, missing_supply_in, chip_overtemp_in} <= 3'h0;
    settle(6);
    host.read(8'h06, d, on, off);
    host.read(8'h06, d, on, off);
    check(fault_pin, 1'b1);
    check(d, 8'h00);
    transmission_fail_in <= 1'b1;
    settle(6);
    check(fault_pin, 1'b0);
    transmission_fail_in <= 1'b0;
    @(posedge mclk);
    output_disable_n <= 1'b0;
    #1;
    check(channel_outputs, 8'h00);
    repeat (`IOH_OUTPUT_DISABLE_N_MIN_CYC) @(posedge mclk);
    output_disable_n <= 1'b1;
    settle(6);
    check(channel_outputs, 8'h00);
    host.read(8'h00, d, on, off);
    check(d, 8'h00);
    do_reset(1'b1);
    for (int m = 0; m < 4; m++) begin
      drv = 8'($random(seed));
      len = (m == 0) ? 8 : ((m == 3) ? 24 : 16);
      {serial_mode_bit1, serial_mode_bit0} <= 2'(m);
      host.frame(ser_bits(m, drv), len, got, on);
      settle(2);
      check(channel_outputs, drv);
      check({on, serial_data_oe}, 2'h2);
    end
    host.frame(24'h0001ff, 9, got, on);
    check(channel_outputs, drv);
    {serial_mode_bit1, serial_mode_bit0} <= 2'h1;
    host.frame({8'h00, ~drv, drv}, 16, got, on);
    settle(2);
    check(channel_outputs, drv);
    check({check_error_flag, fault_pin}, 2'h2);
    {serial_mode_bit1, serial_mode_bit0} <= 2'h2;
    host.frame(24'h0, 16, got, on);
    host.frame(24'h0, 16, got, on);
    check(got[7:0], drv);
    complete_run();
  end
  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    complete_run();
  end
endmodule : ioh_port_test
